// ### ext_bus_defines.svh
// Constants for the external bus cycle and arbitration controller
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define ADDR_W 24
`define DATA_W 16
`define WAIT_W 4
`define MUX_GAP_CYC 2'h1
`define TRI_GAP_CYC 2'h1
`define CS_W 5
`endif

// ### ext_bus_pkg.sv
// Types for the external bus cycle and arbitration controller
`include "ext_bus_defines.svh"
package ext_bus_pkg;
   typedef struct packed {
      logic write;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
   } bus_req_t;
   typedef struct packed {
      logic [`WAIT_W-1:0] waitCount;
      logic cmdDelay;
      logic muxBus;
      logic triWait;
   } bus_cfg_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_CMD = 4'h2,
      S_WAIT = 4'h3,
      S_RDY = 4'h4,
      S_END = 4'h5,
      S_GAP = 4'h6,
      S_HELD = 4'h7,
      S_REGAIN = 4'h8
   } bus_state_t;
endpackage

// ### edge_sync.sv
// Two-stage synchroniser with rising and falling edge detection
`timescale 1ns/10ps
module edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous input and results
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_q, sync_q, prev_q;
   logic meta_d, sync_d, prev_d;
   always_comb begin
      meta_d = din;
      sync_d = meta_q;
      prev_d = sync_q;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule // edge_sync

// ### ext_bus_ctrl.sv
// External bus cycle sequencer with ready stretching and hold arbitration
`timescale 1ns/10ps
`include "ext_bus_defines.svh"
module ext_bus_ctrl
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus clock from the link, sampled here
   input wire logic busClockOutput,
   // Configuration
   input wire bus_cfg_t cfg,
   input wire logic [`CS_W-1:0] csSelect,
   // Internal request and answer
   input wire logic reqValid,
   input wire bus_req_t req,
   output logic reqReady,
   output logic rdValid,
   output logic [`DATA_W-1:0] rdData,
   // Internal wish to own the bus while held
   input wire logic wantBus,
   // External bus pins
   input wire logic readyN,
   input wire logic holdN,
   output logic holdAcknowledgeN,
   output logic busRequestOutN,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic [`ADDR_W-1:0] addrOut,
   output logic addrOe,
   output logic [`DATA_W-1:0] dataOut,
   output logic dataOe,
   input wire logic [`DATA_W-1:0] dataIn,
   output logic [`CS_W-1:0] chipSelectLinesOut,
   output logic [`CS_W-1:0] chipSelectLinesOe,
   output logic strobeOe
);
   logic bclkRise;
   logic rdyLevel, holdLevel;
   edge_sync syncClk (.clk(clk), .rst(rst), .din(busClockOutput),
      .level(), .rise(bclkRise), .fall());
   edge_sync syncRdy (.clk(clk), .rst(rst), .din(readyN),
      .level(rdyLevel), .rise(), .fall());
   edge_sync syncHold (.clk(clk), .rst(rst), .din(holdN),
      .level(holdLevel), .rise(), .fall());

   bus_state_t state_q, state_d;
   bus_req_t cur_q, cur_d;
   logic [`WAIT_W-1:0] wait_q, wait_d;
   logic [1:0] gap_q, gap_d;
   logic rdN_q, rdN_d, wrN_q, wrN_d, owned_q, owned_d;
   logic hold_acknowledge_q, hold_acknowledge_d, bus_request_out_q, bus_request_out_d;
   logic [`DATA_W-1:0] rdData_q, rdData_d;
   logic rdValid_q, rdValid_d;

   // Gap length after a cycle, shared by entry and decisions
   function automatic logic [1:0] gapLen(input bus_cfg_t c);
      gapLen = 2'h0;
      if (c.muxBus) begin
         gapLen = `MUX_GAP_CYC;
         if (c.triWait) begin
            gapLen = 2'(gapLen + `TRI_GAP_CYC);
         end
      end
   endfunction

   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      wait_d = wait_q;
      gap_d = gap_q;
      rdN_d = rdN_q;
      wrN_d = wrN_q;
      owned_d = owned_q;
      hold_acknowledge_d = hold_acknowledge_q;
      bus_request_out_d = bus_request_out_q;
      rdData_d = rdData_q;
      rdValid_d = 1'b0;
      // Everything advances on bus clock rising edges only
      if (bclkRise) begin
         case (state_q)
            S_IDLE: begin
               if (!holdLevel) begin
                  state_d = S_HELD;
                  owned_d = 1'b0;
                  hold_acknowledge_d = 1'b0;
               end else if (reqValid) begin
                  cur_d = req;
                  wait_d = cfg.waitCount;
                  owned_d = 1'b1;
                  state_d = cfg.cmdDelay ? S_ADDR : S_CMD;
                  if (!cfg.cmdDelay) begin
                     rdN_d = req.write;
                     wrN_d = ~req.write;
                  end
               end
            end
            S_ADDR: begin
               rdN_d = cur_q.write;
               wrN_d = ~cur_q.write;
               state_d = S_CMD;
            end
            S_CMD: begin
               state_d = (wait_q != '0) ? S_WAIT : S_RDY;
               wait_d = (wait_q != '0) ? `WAIT_W'(wait_q - 1'b1) : wait_q;
            end
            S_WAIT: begin
               if (wait_q == '0) begin
                  state_d = S_RDY;
               end else begin
                  wait_d = `WAIT_W'(wait_q - 1'b1);
               end
            end
            S_RDY: begin
               if (!rdyLevel) begin
                  state_d = S_END;
                  if (!cur_q.write) begin
                     rdData_d = dataIn;
                     rdValid_d = 1'b1;
                  end
                  rdN_d = 1'b1;
                  wrN_d = 1'b1;
               end
            end
            S_END: begin
               gap_d = gapLen(cfg);
               state_d = (gapLen(cfg) != 2'h0) ? S_GAP : S_IDLE;
            end
            S_GAP: begin
               gap_d = gap_q - 2'h1;
               if (gap_q == 2'h1) begin
                  state_d = S_IDLE;
               end
            end
            S_HELD: begin
               // Request only once bus is released and acknowledged
               bus_request_out_d = ~wantBus;
               if (holdLevel) begin
                  state_d = S_REGAIN;
                  hold_acknowledge_d = 1'b1;
                  bus_request_out_d = 1'b1;
               end
            end
            S_REGAIN: begin
               owned_d = 1'b1;
               state_d = S_IDLE;
            end
            default: begin
               state_d = S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         wait_q <= '0;
         gap_q <= 2'h0;
         rdN_q <= 1'b1;
         wrN_q <= 1'b1;
         owned_q <= 1'b1;
         hold_acknowledge_q <= 1'b1;
         bus_request_out_q <= 1'b1;
         rdData_q <= '0;
         rdValid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cur_q <= cur_d;
         wait_q <= wait_d;
         gap_q <= gap_d;
         rdN_q <= rdN_d;
         wrN_q <= wrN_d;
         owned_q <= owned_d;
         hold_acknowledge_q <= hold_acknowledge_d;
         bus_request_out_q <= bus_request_out_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   assign reqReady = bclkRise && state_q == S_IDLE && holdLevel;
   assign rdValid = rdValid_q;
   assign rdData = rdData_q;
   assign holdAcknowledgeN = hold_acknowledge_q;
   assign busRequestOutN = bus_request_out_q;
   assign readStrobeN = rdN_q;
   assign writeStrobeN = wrN_q;
   assign addrOut = cur_q.addr;
   assign dataOut = cur_q.wdata;
   // Chip selects driven only while owned; the pullup holds them high
   assign chipSelectLinesOut = ~csSelect | {`CS_W{state_q == S_IDLE || state_q == S_GAP}};
   assign chipSelectLinesOe = {`CS_W{owned_q}};
   assign addrOe = owned_q;
   assign strobeOe = owned_q;
   assign dataOe = owned_q && cur_q.write && !wrN_q;

   ready_ext_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == S_RDY && bclkRise && rdyLevel) |=> state_q == S_RDY)
      else $error("ready high did not stretch cycle");
   ready_end_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == S_RDY && bclkRise && !rdyLevel) |=> state_q == S_END && readStrobeN)
      else $error("ready low did not end cycle");
   wait_count_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == S_WAIT && bclkRise && wait_q != '0) |=> state_q == S_WAIT)
      else $error("wait states cut short");
   cmd_delay_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == S_ADDR) |-> readStrobeN && writeStrobeN)
      else $error("command asserted during delay");
   gap_zero_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == S_END && bclkRise && !cfg.muxBus) |=> state_q == S_IDLE)
      else $error("gap inserted on demultiplexed bus");
   grant_idle_a: assert property (@(posedge clk) disable iff (rst)
      $fell(holdAcknowledgeN) |-> $past(state_q) == S_IDLE)
      else $error("bus granted mid cycle");
   bus_request_out_after_a: assert property (@(posedge clk) disable iff (rst)
      !busRequestOutN |-> !holdAcknowledgeN && !addrOe)
      else $error("bus request before release");
   release_float_a: assert property (@(posedge clk) disable iff (rst)
      !holdAcknowledgeN |-> chipSelectLinesOe == '0 && !strobeOe)
      else $error("bus still driven while released");
   regain_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(holdAcknowledgeN) |-> $past(holdLevel))
      else $error("regain without hold high");
   read_latch_a: assert property (@(posedge clk) disable iff (rst)
      rdValid |-> $rose(readStrobeN))
      else $error("read data not latched at strobe rise");
endmodule // ext_bus_ctrl

// ### ext_bus_mem_model.sv
// Behavioural memory on the far side of the external bus
`timescale 1ns/10ps
module ext_bus_mem_model (
   // Bus pins seen by the memory
   input wire logic busClockOutput,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic [23:0] addrOut,
   input wire logic [15:0] dataOut,
   // Stretch in bus clock falls, set by the bench
   input wire logic [3:0] readyDelay,
   // Answers
   output logic readyN,
   output logic [15:0] dataIn,
   output logic [15:0] wrSeen
);
   // Known start so the first command does not count from an unknown value
   logic [3:0] cnt = 4'h0;
   logic cmdLow;
   assign cmdLow = !(readStrobeN && writeStrobeN);
   // Cleared with the command so a stale count never answers early
   always @(negedge busClockOutput or negedge cmdLow) begin
      if (!cmdLow) cnt <= 4'h0;
      else cnt <= cnt + 4'h1;
   end
   // Ready withdrawn with the rising command edge, pull-up after
   assign readyN = !(cmdLow && cnt >= readyDelay);
   // Released data shows the inverse so a late latch cannot match
   assign dataIn = {16{readStrobeN}} ^ addrOut[15:0] ^ 16'h5a3c;
   always @(posedge writeStrobeN) wrSeen <= dataOut;
endmodule // ext_bus_mem_model

// ### ext_bus_ctrl_tb_top.sv
// Testbench for the external bus sequencer and hold arbitration
`timescale 1ns/10ps
module ext_bus_ctrl_tb_top;
   import ext_bus_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic busClockOutput = 1'b0;
   bus_cfg_t cfg = '0;
   bus_req_t req = '0;
   logic reqValid = 1'b0;
   logic wantBus = 1'b0;
   logic holdN = 1'b1;
   logic [3:0] readyDelay = 4'h1;
   logic reqReady, rdValid, readyN, holdAcknowledgeN, busRequestOutN, bclkQ;
   logic readStrobeN, writeStrobeN, addrOe, dataOe, strobeOe;
   logic [23:0] addrOut;
   logic [15:0] rdData, dataOut, dataIn, wrSeen;
   logic [4:0] csOut, csOe, csWire;
   int mismatches = 0;
   int n_tests = 0;
   int bclks = 0;
   int lowEdges = 0;
   always #2 clk = ~clk;
   always #40 busClockOutput = ~busClockOutput;
   // Undriven chip selects rest high through the pull-up
   assign csWire = (csOut & csOe) | ~csOe;
   always @(posedge clk) begin
      bclkQ <= busClockOutput;
      if (busClockOutput && !bclkQ) begin
         bclks++;
         if (!(readStrobeN && writeStrobeN)) lowEdges++;
      end
   end
   ext_bus_ctrl ext_bus_ctrl_inst (.clk(clk), .rst(rst), .busClockOutput(busClockOutput),
      .cfg(cfg), .csSelect(5'h01), .reqValid(reqValid), .req(req), .reqReady(reqReady),
      .rdValid(rdValid), .rdData(rdData), .wantBus(wantBus), .readyN(readyN), .holdN(holdN),
      .holdAcknowledgeN(holdAcknowledgeN), .busRequestOutN(busRequestOutN),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .addrOut(addrOut),
      .addrOe(addrOe), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
      .chipSelectLinesOut(csOut), .chipSelectLinesOe(csOe), .strobeOe(strobeOe));
   ext_bus_mem_model ext_bus_mem_model_inst (.busClockOutput(busClockOutput),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .addrOut(addrOut),
      .dataOut(dataOut), .readyDelay(readyDelay), .readyN(readyN), .dataIn(dataIn),
      .wrSeen(wrSeen));
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return reqReady;
         1: return rdValid;
         2: return readStrobeN;
         3: return holdAcknowledgeN;
         4: return busRequestOutN;
         default: return writeStrobeN;
      endcase
   endfunction
   task automatic waitFor(input int k, input logic lvl);
      int i;
      for (i = 0; i < 2000 && pick(k) !== lvl; i++) @(negedge clk);
      if (i == 2000) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic issue(input logic wr, input logic [23:0] a, input logic [15:0] d);
      @(negedge clk);
      req = '{write: wr, addr: a, wdata: d};
      reqValid = 1'b1;
      waitFor(0, 1'b1);
      @(negedge clk);
      reqValid = 1'b0;
      bclks = 0;
   endtask
   task automatic readCase(input logic [3:0] w, input logic [3:0] k, input logic d);
      cfg = '{waitCount: w, cmdDelay: d, muxBus: 1'b0, triWait: 1'b0};
      // First ready sample falls on the second edge after the waits
      readyDelay = w + k + 4'h2;
      issue(1'b0, 24'h00a5c3 + w, 16'h0);
      waitFor(2, 1'b0);
      lowEdges = 0;
      check(bclks, d);
      check(csWire, 5'h1e);
      waitFor(1, 1'b1);
      check(rdData, 16'ha5c3 + w ^ 16'h5a3c);
      if (!d) check(lowEdges, w + k + 2);
      waitFor(2, 1'b1);
   endtask
   task automatic writeCase(input logic [15:0] d);
      cfg = '{waitCount: 4'h1, cmdDelay: 1'b0, muxBus: 1'b0, triWait: 1'b0};
      readyDelay = 4'h3;
      issue(1'b1, 24'h001234, d);
      waitFor(5, 1'b0);
      check(dataOe, 1'b1);
      waitFor(5, 1'b1);
      check(wrSeen, d);
   endtask
   task automatic gapCase(input logic multiplexed_bus, input logic triOn, input int exp);
      cfg = '{waitCount: 4'h0, cmdDelay: 1'b0, muxBus: multiplexed_bus, triWait: triOn};
      readyDelay = 4'h1;
      issue(1'b0, 24'h000010, 16'h0);
      waitFor(2, 1'b0);
      waitFor(2, 1'b1);
      bclks = 0;
      // Next request waits through the gap; edges counted until its command
      @(negedge clk);
      req.addr = 24'h000020;
      reqValid = 1'b1;
      waitFor(0, 1'b1);
      @(negedge clk);
      reqValid = 1'b0;
      waitFor(2, 1'b0);
      check(bclks, exp);
      waitFor(2, 1'b1);
   endtask
   task automatic holdCase(input logic want);
      cfg = '0;
      // Stretched cycle so the hold request lands mid-cycle
      readyDelay = 4'h4;
      issue(1'b0, 24'h000100, 16'h0);
      waitFor(2, 1'b0);
      holdN = 1'b0;
      waitFor(2, 1'b1);
      check(holdAcknowledgeN, 1'b1);
      waitFor(3, 1'b0);
      check(busRequestOutN, 1'b1);
      repeat (2) @(negedge clk);
      check({csWire, addrOe, dataOe, strobeOe}, 32'hf8);
      wantBus = want;
      if (want) waitFor(4, 1'b0);
      repeat (100) @(negedge clk);
      check(holdAcknowledgeN, 1'b0);
      holdN = 1'b1;
      waitFor(3, 1'b1);
      check(busRequestOutN, 1'b1);
      wantBus = 1'b0;
      readCase(4'h0, 4'h0, 1'b0);
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      readCase(4'h0, 4'h0, 1'b0);
      readCase(4'h2, 4'h2, 1'b0);
      readCase(4'h1, 4'h0, 1'b1);
      writeCase(16'hc35a);
      gapCase(1'b0, 1'b0, 2);
      gapCase(1'b1, 1'b0, 3);
      gapCase(1'b1, 1'b1, 4);
      holdCase(1'b1);
      holdCase(1'b0);
      summarize();
   end
endmodule // ext_bus_ctrl_tb_top
